// ===== hdl/bit_sync2.sv
`timescale 1ns/100ps
module bit_sync2 (
  input  wire logic i_clock,
  input  wire logic i_arst_n,
  input  wire logic i_async,
  output logic      o_sync
);
  logic meta_ff;
  logic sync_ff;

  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      meta_ff <= 1'b0;
      sync_ff <= 1'b0;
    end else begin
      meta_ff <= i_async;
      sync_ff <= meta_ff;
    end
  end

  assign o_sync = sync_ff;
endmodule // bit_sync2

// ===== hdl/machine_cycle_timer.sv
`timescale 1ns/100ps
module machine_cycle_timer #(
  parameter int PERIODS     = 12,
  parameter int SAMPLE_TICK = 9
) (
  input  wire logic i_clock,
  input  wire logic i_arst_n,
  output logic      o_sample
);
  localparam int CW = $clog2(PERIODS);
  localparam logic [CW-1:0] LAST = CW'(PERIODS - 1);
  localparam logic [CW-1:0] TICK = CW'(SAMPLE_TICK);

  logic [CW-1:0] count_ff;
  logic [CW-1:0] nxt_count;
  logic          sample_ff;
  logic          nxt_sample;

  always_comb begin
    nxt_count  = (count_ff == LAST) ? '0 : count_ff + 1'b1;
    nxt_sample = (nxt_count == TICK);
  end

  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      count_ff  <= '0;
      sample_ff <= 1'b0;
    end else begin
      count_ff  <= nxt_count;
      sample_ff <= nxt_sample;
    end
  end

  assign o_sample = sample_ff;
endmodule // machine_cycle_timer

// ===== hdl/mcu_reset_sequencer.sv
// How it works
// - Reset comes from the external pin or the internal power-on detector.
// - Core registers except the serial buffer clear on reset; stack pointer gets 07; undefined bits hold.
// - Port latches go to build-time levels, all ones by default.
// - Filtered pin sampled once per machine cycle at state 5 phase 2.
// - Internal reset repeats each machine cycle until the pin samples low.
// - Port pins forced to reset levels as soon as the pin is high.
// - Address latch strobe and program store strobe held high during reset.
// - Internal data RAM keeps its contents across every reset.
// - Valid supply drives port levels, then CPU held 1536 periods, clocks off.
// - Power-on detector output is taken as a clean digital level.
// - Internal power-on reset can be removed at build time.
// - Fixed variants: no power-on reset, all-high ports, medium oscillator.
//
// The address map and the Avalon-MM interface to the registers are this design's own decisions.
`timescale 1ns/100ps
module mcu_reset_sequencer
  import rst_seq_pkg::*;
#(
  parameter bit          POR_PRESENT          = 1'b1,
  parameter bit          FIXED_OPTION_VARIANT = 1'b0,
  parameter logic [31:0] PORT_RESET_LEVELS    = PORT_RESET_DEFAULT,
  parameter logic [2:0]  OSC_OPTION           = OSC_OPT_MEDIUM,
  parameter int          RAM_DEPTH            = RAM_DEPTH_DEFAULT
) (
  input  wire logic        i_clock,
  input  wire logic        i_arst_n,
  input  wire logic        i_rst_pin,
  input  wire logic        i_power_ok,
  input  wire logic        i_cpu_ale,
  input  wire logic        i_cpu_prog_store_strobe,
  input  wire logic [7:0]  i_avs_address,
  input  wire logic        i_avs_read,
  input  wire logic        i_avs_write,
  input  wire logic [31:0] i_avs_writedata,
  input  wire logic [3:0]  i_avs_byteenable,
  output logic [31:0]      o_avs_readdata,
  output logic             o_avs_waitrequest,
  output logic             o_cpu_reset,
  output logic             o_cpu_clock_en,
  output logic [31:0]      o_port_latches,
  output logic             o_ale,
  output logic             o_prog_store_strobe,
  output logic [2:0]       o_osc_option
);
  // Build options
  localparam bit          POR_EN      = POR_PRESENT && !FIXED_OPTION_VARIANT;
  localparam logic [31:0] PORT_LEVELS =
    FIXED_OPTION_VARIANT ? PORT_RESET_DEFAULT : PORT_RESET_LEVELS;
  localparam logic [2:0]  OSC_OPT     = FIXED_OPTION_VARIANT ? OSC_OPT_MEDIUM : OSC_OPTION;
  localparam int          RAM_AW      = $clog2(RAM_DEPTH);
  localparam logic [SETTLE_CNT_W-1:0] SETTLE_LAST = SETTLE_CNT_W'(SETTLE_CYCLES - 1);

  function automatic logic [7:0] lane0_write(input logic [7:0] old_val,
                                             input logic [31:0] wdata,
                                             input logic [3:0] be);
    lane0_write = be[0] ? wdata[7:0] : old_val;
  endfunction

  function automatic logic [7:0] keep_undefined(input logic [7:0] old_val,
                                                input logic [7:0] def_mask);
    keep_undefined = old_val & ~def_mask;
  endfunction

  // Input synchronisers and machine-cycle timing
  logic pin_sync;
  logic power_sync;
  logic sample_pulse;

  bit_sync2 u_pin_sync (
    .i_clock  (i_clock),
    .i_arst_n (i_arst_n),
    .i_async  (i_rst_pin),
    .o_sync   (pin_sync)
  );

  bit_sync2 u_power_sync (
    .i_clock  (i_clock),
    .i_arst_n (i_arst_n),
    .i_async  (i_power_ok),
    .o_sync   (power_sync)
  );

  machine_cycle_timer #(
    .PERIODS     (OSC_PER_MACHINE_CYCLE),
    .SAMPLE_TICK (SAMPLE_TICK)
  ) u_mc_timer (
    .i_clock  (i_clock),
    .i_arst_n (i_arst_n),
    .o_sample (sample_pulse)
  );

  // Reset sources
  por_state_type           por_state_ff;
  por_state_type           nxt_por_state;
  logic [SETTLE_CNT_W-1:0] settle_cnt_ff;
  logic [SETTLE_CNT_W-1:0] nxt_settle_cnt;
  logic                    sampled_ff;
  logic                    nxt_sampled;
  logic                    por_hold;
  logic                    in_reset;
  logic                    port_force;

  always_comb begin
    nxt_sampled    = sample_pulse ? pin_sync : sampled_ff;
    nxt_por_state  = por_state_ff;
    nxt_settle_cnt = '0;
    case (por_state_ff)
      POWER_LOW: begin
        if (!POR_EN) begin
          nxt_por_state = RUN;
        end else if (power_sync) begin
          nxt_por_state = SETTLE;
        end
      end
      SETTLE: begin
        nxt_settle_cnt = settle_cnt_ff + 1'b1;
        if (!power_sync) begin
          nxt_por_state = POWER_LOW;
        end else if (settle_cnt_ff == SETTLE_LAST) begin
          nxt_por_state = RUN;
        end
      end
      RUN: begin
        if (POR_EN && !power_sync) begin
          nxt_por_state = POWER_LOW;
        end
      end
      default: nxt_por_state = POWER_LOW;
    endcase
  end

  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      por_state_ff  <= POWER_LOW;
      settle_cnt_ff <= '0;
      sampled_ff    <= 1'b0;
    end else begin
      por_state_ff  <= nxt_por_state;
      settle_cnt_ff <= nxt_settle_cnt;
      sampled_ff    <= nxt_sampled;
    end
  end

  assign por_hold   = (por_state_ff != RUN);
  assign in_reset   = sampled_ff || por_hold;
  assign port_force = pin_sync || in_reset;

  // Core register file and bus slave
  logic [7:0]  accum_ff, nxt_accum;
  logic [7:0]  stack_ff, nxt_stack;
  logic [7:0]  prio_ff, nxt_prio;
  logic [7:0]  pwr_ff, nxt_pwr;
  logic [7:0]  tmode_ff, nxt_tmode;
  logic [7:0]  tctl_ff, nxt_tctl;
  logic [7:0]  sbuf_ff, nxt_sbuf;
  logic [31:0] latch_ff, nxt_latch;
  logic [31:0] rdata_ff, nxt_rdata;
  logic        wait_ff, nxt_wait;
  logic [7:0]  ram_mem [RAM_DEPTH];
  logic        ram_we;
  logic        is_ram;
  logic        wr_take;
  logic        rd_start;
  logic [RAM_AW-1:0] ram_idx;
  logic [31:0] status;

  assign ram_idx = i_avs_address[RAM_AW+1:2];
  assign is_ram  = (int'(i_avs_address) >= int'(RAM_BASE_OFS)) &&
                   (int'(i_avs_address) < int'(RAM_BASE_OFS) + RAM_DEPTH * 4);
  assign wr_take  = i_avs_write && !wait_ff;
  assign rd_start = i_avs_read && wait_ff;

  always_comb begin
    status               = '0;
    status[ST_CPU_RESET] = in_reset;
    status[ST_SETTLING]  = (por_state_ff == SETTLE);
    status[ST_SAMPLED]   = sampled_ff;
    status[ST_PIN_LEVEL] = pin_sync;
    status[ST_CLOCK_EN]  = !por_hold;
    status[ST_POWER_OK]  = power_sync;
  end

  always_comb begin
    nxt_accum = accum_ff;
    nxt_stack = stack_ff;
    nxt_prio  = prio_ff;
    nxt_pwr   = pwr_ff;
    nxt_tmode = tmode_ff;
    nxt_tctl  = tctl_ff;
    nxt_sbuf  = sbuf_ff;
    nxt_latch = latch_ff;
    nxt_rdata = rdata_ff;
    nxt_wait  = !((i_avs_read || i_avs_write) && wait_ff);
    ram_we    = 1'b0;
    if (wr_take) begin
      if (i_avs_address == ACCUMULATOR_OFS) begin
        nxt_accum = lane0_write(accum_ff, i_avs_writedata, i_avs_byteenable);
      end else if (i_avs_address == STACK_PTR_OFS) begin
        nxt_stack = lane0_write(stack_ff, i_avs_writedata, i_avs_byteenable);
      end else if (i_avs_address == PRIO_ZERO_OFS) begin
        nxt_prio = lane0_write(prio_ff, i_avs_writedata, i_avs_byteenable);
      end else if (i_avs_address == PWR_CTRL_OFS) begin
        nxt_pwr = lane0_write(pwr_ff, i_avs_writedata, i_avs_byteenable);
      end else if (i_avs_address == TIMER_MODE_OFS) begin
        nxt_tmode = lane0_write(tmode_ff, i_avs_writedata, i_avs_byteenable);
      end else if (i_avs_address == TIMER_CTRL_OFS) begin
        nxt_tctl = lane0_write(tctl_ff, i_avs_writedata, i_avs_byteenable);
      end else if (i_avs_address == SERIAL_BUF_OFS) begin
        nxt_sbuf = lane0_write(sbuf_ff, i_avs_writedata, i_avs_byteenable);
      end else if (i_avs_address == PORT_LATCH_OFS) begin
        for (int b = 0; b < 4; b++) begin
          if (i_avs_byteenable[b]) begin
            nxt_latch[b*8 +: 8] = i_avs_writedata[b*8 +: 8];
          end
        end
      end else if (is_ram) begin
        ram_we = i_avs_byteenable[0];
      end
    end
    if (rd_start) begin
      if (i_avs_address == ACCUMULATOR_OFS) begin
        nxt_rdata = {24'h00_0000, accum_ff};
      end else if (i_avs_address == STACK_PTR_OFS) begin
        nxt_rdata = {24'h00_0000, stack_ff};
      end else if (i_avs_address == PRIO_ZERO_OFS) begin
        nxt_rdata = {24'h00_0000, prio_ff};
      end else if (i_avs_address == PWR_CTRL_OFS) begin
        nxt_rdata = {24'h00_0000, pwr_ff};
      end else if (i_avs_address == TIMER_MODE_OFS) begin
        nxt_rdata = {24'h00_0000, tmode_ff};
      end else if (i_avs_address == TIMER_CTRL_OFS) begin
        nxt_rdata = {24'h00_0000, tctl_ff};
      end else if (i_avs_address == SERIAL_BUF_OFS) begin
        nxt_rdata = {24'h00_0000, sbuf_ff};
      end else if (i_avs_address == PORT_LATCH_OFS) begin
        nxt_rdata = latch_ff;
      end else if (i_avs_address == STATUS_OFS) begin
        nxt_rdata = status;
      end else if (is_ram) begin
        nxt_rdata = {24'h00_0000, ram_mem[ram_idx]};
      end else begin
        nxt_rdata = '0;
      end
    end
    if (in_reset) begin
      nxt_accum = ZERO_RESET;
      nxt_stack = STACK_PTR_RESET;
      nxt_prio  = keep_undefined(prio_ff, PRIO_ZERO_DEF_MASK);
      nxt_pwr   = keep_undefined(pwr_ff, PWR_CTRL_DEF_MASK);
      nxt_tmode = ZERO_RESET;
      nxt_tctl  = ZERO_RESET;
      nxt_sbuf  = sbuf_ff;
      nxt_latch = PORT_LEVELS;
    end
  end

  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      accum_ff <= ZERO_RESET;
      stack_ff <= STACK_PTR_RESET;
      prio_ff  <= ZERO_RESET;
      pwr_ff   <= ZERO_RESET;
      tmode_ff <= ZERO_RESET;
      tctl_ff  <= ZERO_RESET;
      sbuf_ff  <= ZERO_RESET;
      latch_ff <= PORT_LEVELS;
      rdata_ff <= '0;
      wait_ff  <= 1'b1;
    end else begin
      accum_ff <= nxt_accum;
      stack_ff <= nxt_stack;
      prio_ff  <= nxt_prio;
      pwr_ff   <= nxt_pwr;
      tmode_ff <= nxt_tmode;
      tctl_ff  <= nxt_tctl;
      sbuf_ff  <= nxt_sbuf;
      latch_ff <= nxt_latch;
      rdata_ff <= nxt_rdata;
      wait_ff  <= nxt_wait;
    end
  end

  // Data RAM has no reset path
  always_ff @(posedge i_clock) begin
    if (ram_we) begin
      ram_mem[ram_idx] <= i_avs_writedata[7:0];
    end
  end

  // Pin-facing outputs
  logic        cpu_reset_ff, nxt_cpu_reset;
  logic        clk_en_ff, nxt_clk_en;
  logic [31:0] port_ff, nxt_port;
  logic        ale_ff, nxt_ale;
  logic        pss_ff, nxt_pss;
  logic [2:0]  osc_ff;

  always_comb begin
    nxt_cpu_reset = in_reset;
    nxt_clk_en    = !por_hold;
    nxt_port      = port_force ? PORT_LEVELS : latch_ff;
    nxt_ale       = in_reset ? 1'b1 : i_cpu_ale;
    nxt_pss       = in_reset ? 1'b1 : i_cpu_prog_store_strobe;
  end

  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      cpu_reset_ff <= 1'b1;
      clk_en_ff    <= 1'b0;
      port_ff      <= PORT_LEVELS;
      ale_ff       <= 1'b1;
      pss_ff       <= 1'b1;
      osc_ff       <= OSC_OPT;
    end else begin
      cpu_reset_ff <= nxt_cpu_reset;
      clk_en_ff    <= nxt_clk_en;
      port_ff      <= nxt_port;
      ale_ff       <= nxt_ale;
      pss_ff       <= nxt_pss;
      osc_ff       <= OSC_OPT;
    end
  end

  assign o_cpu_reset         = cpu_reset_ff;
  assign o_cpu_clock_en      = clk_en_ff;
  assign o_port_latches      = port_ff;
  assign o_ale               = ale_ff;
  assign o_prog_store_strobe = pss_ff;
  assign o_osc_option        = osc_ff;
  assign o_avs_readdata      = rdata_ff;
  assign o_avs_waitrequest   = wait_ff;

  // Checks
  strobes_held_a: assert property (@(posedge i_clock) disable iff (!i_arst_n)
    cpu_reset_ff |-> (ale_ff && pss_ff))
    else $error("strobe low during reset");

  sample_point_a: assert property (@(posedge i_clock) disable iff (!i_arst_n)
    (sampled_ff != $past(sampled_ff)) |-> $past(sample_pulse))
    else $error("pin sampled off the sample point");

  reset_repeat_a: assert property (@(posedge i_clock) disable iff (!i_arst_n)
    sampled_ff |=> cpu_reset_ff)
    else $error("internal reset dropped while pin sampled high");

  port_force_a: assert property (@(posedge i_clock) disable iff (!i_arst_n)
    pin_sync |=> (port_ff == PORT_LEVELS))
    else $error("ports not forced while pin high");

  reg_reset_a: assert property (@(posedge i_clock) disable iff (!i_arst_n)
    in_reset |=> (stack_ff == STACK_PTR_RESET && accum_ff == ZERO_RESET &&
                  latch_ff == PORT_LEVELS))
    else $error("core register reset value wrong");

  settle_len_a: assert property (@(posedge i_clock) disable iff (!i_arst_n)
    ($past(por_state_ff) == SETTLE && por_state_ff == RUN)
      |-> ($past(settle_cnt_ff) == SETTLE_LAST))
    else $error("settling delay length wrong");

  clock_gate_a: assert property (@(posedge i_clock) disable iff (!i_arst_n)
    por_hold |=> (!clk_en_ff && cpu_reset_ff))
    else $error("clock enabled during settling");

  por_removed_a: assert property (@(posedge i_clock) disable iff (!i_arst_n)
    (!POR_EN && por_state_ff == RUN) |=> (por_state_ff == RUN))
    else $error("power-on hold without detector");

  bus_answer_a: assert property (@(posedge i_clock) disable iff (!i_arst_n)
    ((i_avs_read || i_avs_write) && wait_ff) |=> !wait_ff ##1 wait_ff)
    else $error("bus answer not one cycle");
endmodule // mcu_reset_sequencer

// ===== hdl/rst_seq_pkg.sv
package rst_seq_pkg;
  // Clocking: the design clock is the oscillator
  localparam int CLOCK_PERIOD_NS       = 40;
  localparam int OSC_PERIOD_NS         = 40;
  localparam int OSC_PER_MACHINE_CYCLE = 12;
  localparam int SAMPLE_STATE          = 5;
  localparam int SAMPLE_PHASE          = 2;
  localparam int SAMPLE_TICK           = (SAMPLE_STATE - 1) * 2 + (SAMPLE_PHASE - 1);
  localparam int SETTLE_OSC_PERIODS    = 1536;
  localparam int SETTLE_CYCLES         =
    (SETTLE_OSC_PERIODS * OSC_PERIOD_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
  localparam int SETTLE_CNT_W          = $clog2(SETTLE_CYCLES);

  // Reset contents
  localparam logic [7:0]  ZERO_RESET         = 8'h00;
  localparam logic [7:0]  STACK_PTR_RESET    = 8'h07;
  localparam logic [7:0]  PRIO_ZERO_DEF_MASK = 8'h3f;
  localparam logic [7:0]  PWR_CTRL_DEF_MASK  = 8'h8f;
  localparam logic [31:0] PORT_RESET_DEFAULT = 32'hffff_ffff;
  localparam logic [2:0]  OSC_OPT_MEDIUM     = 3'h3;

  // Register byte offsets
  localparam logic [7:0] ACCUMULATOR_OFS = 8'h00;
  localparam logic [7:0] STACK_PTR_OFS   = 8'h04;
  localparam logic [7:0] PRIO_ZERO_OFS   = 8'h08;
  localparam logic [7:0] PWR_CTRL_OFS    = 8'h0c;
  localparam logic [7:0] TIMER_MODE_OFS  = 8'h10;
  localparam logic [7:0] TIMER_CTRL_OFS  = 8'h14;
  localparam logic [7:0] SERIAL_BUF_OFS  = 8'h18;
  localparam logic [7:0] PORT_LATCH_OFS  = 8'h1c;
  localparam logic [7:0] STATUS_OFS      = 8'h20;
  localparam logic [7:0] RAM_BASE_OFS    = 8'h80;
  localparam int         RAM_DEPTH_DEFAULT = 16;

  // Status fields
  localparam int ST_CPU_RESET = 0;
  localparam int ST_SETTLING  = 1;
  localparam int ST_SAMPLED   = 2;
  localparam int ST_PIN_LEVEL = 3;
  localparam int ST_CLOCK_EN  = 4;
  localparam int ST_POWER_OK  = 5;

  typedef enum logic [1:0] {
    POWER_LOW = 2'b00,
    SETTLE    = 2'b01,
    RUN       = 2'b11
  } por_state_type;
endpackage

// ===== verification/reset_source_model.sv
`timescale 1ns/100ps
module reset_source_model #(
  parameter int HOLD_CYCLES = 24
) (
  input  wire logic i_clock,
  input  wire logic i_supply_on,
  input  wire logic i_pulse_go,
  output logic      o_rst_pin,
  output logic      o_power_ok
);
  int hold_ff;

  initial begin
    hold_ff    = 0;
    o_power_ok = 1'b0;
  end

  // Supply monitor gives a clean level
  always @(posedge i_clock) begin
    o_power_ok <= i_supply_on;
  end

  // Pin held high two machine cycles or longer
  always @(posedge i_clock) begin
    if (i_pulse_go) begin
      hold_ff <= HOLD_CYCLES;
    end else if (hold_ff > 0) begin
      hold_ff <= hold_ff - 1;
    end
  end

  assign o_rst_pin = (hold_ff != 0);
endmodule // reset_source_model

// ===== verification/testbench.sv
`timescale 1ns/100ps
module testbench;
  import rst_seq_pkg::*;
  logic        clock;
  logic        arst_n;
  logic        supply_on;
  logic        pulse_go;
  logic        rst_pin;
  logic        power_ok;
  logic        cpu_ale;
  logic        cpu_pss;
  logic [7:0]  address;
  logic        read;
  logic        write;
  logic [31:0] wdata;
  logic [31:0] rdata;
  logic        waitreq;
  logic        cpu_reset;
  logic        clock_en;
  logic [31:0] ports;
  logic        ale;
  logic        pss;
  logic [2:0]  osc;
  logic        fx_cpu_reset;
  logic [2:0]  fx_osc;
  int          err_total;
  int          checked;
  int          cycles;

  reset_source_model reset_source_model_i (
    .i_clock     (clock),
    .i_supply_on (supply_on),
    .i_pulse_go  (pulse_go),
    .o_rst_pin   (rst_pin),
    .o_power_ok  (power_ok)
  );

  mcu_reset_sequencer mcu_reset_sequencer_i (
    .i_clock                 (clock),
    .i_arst_n                (arst_n),
    .i_rst_pin               (rst_pin),
    .i_power_ok              (power_ok),
    .i_cpu_ale               (cpu_ale),
    .i_cpu_prog_store_strobe (cpu_pss),
    .i_avs_address           (address),
    .i_avs_read              (read),
    .i_avs_write             (write),
    .i_avs_writedata         (wdata),
    .i_avs_byteenable        (4'hf),
    .o_avs_readdata          (rdata),
    .o_avs_waitrequest       (waitreq),
    .o_cpu_reset             (cpu_reset),
    .o_cpu_clock_en          (clock_en),
    .o_port_latches          (ports),
    .o_ale                   (ale),
    .o_prog_store_strobe     (pss),
    .o_osc_option            (osc)
  );

  mcu_reset_sequencer #(.FIXED_OPTION_VARIANT(1'b1)) fixed_mcu_reset_sequencer_i (
    .i_clock                 (clock),
    .i_arst_n                (arst_n),
    .i_rst_pin               (rst_pin),
    .i_power_ok              (power_ok),
    .i_cpu_ale               (cpu_ale),
    .i_cpu_prog_store_strobe (cpu_pss),
    .i_avs_address           (address),
    .i_avs_read              (read),
    .i_avs_write             (write),
    .i_avs_writedata         (wdata),
    .i_avs_byteenable        (4'hf),
    .o_avs_readdata          (),
    .o_avs_waitrequest       (),
    .o_cpu_reset             (fx_cpu_reset),
    .o_cpu_clock_en          (),
    .o_port_latches          (),
    .o_ale                   (),
    .o_prog_store_strobe     (),
    .o_osc_option            (fx_osc)
  );

  initial begin
    clock = 1'b0;
    forever #(CLOCK_PERIOD_NS / 2) clock = ~clock;
  end

  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      err_total = err_total + 1;
      wrap_up();
    end
  end

  task automatic wrap_up();
    $display("mismatches %0d of %0d compares", err_total, checked);
    if (err_total == 0 && checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked = checked + 1;
    if (seen !== exp) begin
      err_total = err_total + 1;
      $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic bus_wait();
    @(posedge clock);
    while (waitreq !== 1'b0) begin
      @(posedge clock);
    end
  endtask

  task automatic bus_wr(input logic [7:0] a, input logic [31:0] d);
    address <= a;
    wdata   <= d;
    write   <= 1'b1;
    bus_wait();
    write   <= 1'b0;
    @(posedge clock);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] d;
    address <= a;
    read    <= 1'b1;
    bus_wait();
    d = rdata;
    read    <= 1'b0;
    @(posedge clock);
    chk(d, exp);
  endtask

  task automatic t_power_on();
    int n;
    n = 0;
    #1;
    chk(fx_osc, OSC_OPT_MEDIUM);
    chk(osc, OSC_OPT_MEDIUM);
    chk(fx_cpu_reset, 1'b0);
    chk(cpu_reset, 1'b1);
    chk(ports, PORT_RESET_DEFAULT);
    @(posedge clock);
    supply_on <= 1'b1;
    while (cpu_reset !== 1'b0 && n < 1700) begin
      @(posedge clock);
      #1;
      if (n == 1500) begin
        chk({clock_en, ale, pss}, 3'b011);
        chk(ports, PORT_RESET_DEFAULT);
      end
      n = n + 1;
    end
    chk(n >= 1536 && n <= 1544, 1'b1);
    chk(clock_en, 1'b1);
    @(posedge clock);
    rd_chk(ACCUMULATOR_OFS, 32'h0);
    rd_chk(STACK_PTR_OFS, {24'h0, STACK_PTR_RESET});
    rd_chk(TIMER_MODE_OFS, 32'h0);
    rd_chk(TIMER_CTRL_OFS, 32'h0);
    rd_chk(PORT_LATCH_OFS, PORT_RESET_DEFAULT);
  endtask

  task automatic t_pin_reset();
    int n;
    n = 0;
    bus_wr(ACCUMULATOR_OFS, 32'h5a);
    bus_wr(STACK_PTR_OFS, 32'h33);
    bus_wr(TIMER_MODE_OFS, 32'h11);
    bus_wr(PRIO_ZERO_OFS, 32'hff);
    bus_wr(PWR_CTRL_OFS, 32'hff);
    bus_wr(SERIAL_BUF_OFS, 32'h3c);
    bus_wr(PORT_LATCH_OFS, 32'h1234_5678);
    bus_wr(RAM_BASE_OFS, 32'ha5);
    rd_chk(ACCUMULATOR_OFS, 32'h5a);
    #1;
    chk({ale, pss}, 2'b00);
    chk(ports, 32'h1234_5678);
    @(posedge clock);
    pulse_go <= 1'b1;
    @(posedge clock);
    pulse_go <= 1'b0;
    repeat (3) @(posedge clock);
    #1;
    chk(ports, PORT_RESET_DEFAULT);
    repeat (14) @(posedge clock);
    #1;
    chk({cpu_reset, ale, pss}, 3'b111);
    @(posedge clock);
    bus_wr(ACCUMULATOR_OFS, 32'h77);
    rd_chk(STATUS_OFS, 32'h3d);
    #1;
    while (cpu_reset !== 1'b0 && n < 60) begin
      @(posedge clock);
      #1;
      n = n + 1;
    end
    chk({rst_pin, n < 60}, 2'b01);
    @(posedge clock);
    rd_chk(ACCUMULATOR_OFS, 32'h0);
    rd_chk(STACK_PTR_OFS, 32'h7);
    rd_chk(TIMER_MODE_OFS, 32'h0);
    rd_chk(PRIO_ZERO_OFS, 32'hc0);
    rd_chk(PWR_CTRL_OFS, 32'h70);
    rd_chk(SERIAL_BUF_OFS, 32'h3c);
    rd_chk(PORT_LATCH_OFS, PORT_RESET_DEFAULT);
    rd_chk(RAM_BASE_OFS, 32'ha5);
    #1;
    chk({ale, pss}, 2'b00);
  endtask

  task automatic t_bus_misc();
    @(posedge clock);
    bus_wr(8'h40, 32'hffff_ffff);
    rd_chk(8'h40, 32'h0);
    bus_wr(STATUS_OFS, 32'h0);
    rd_chk(STATUS_OFS, 32'h30);
    supply_on <= 1'b0;
    repeat (6) @(posedge clock);
    #1;
    chk({cpu_reset, clock_en}, 2'b10);
    @(posedge clock);
    rd_chk(RAM_BASE_OFS, 32'ha5);
  endtask

  initial begin
    err_total = 0;
    checked   = 0;
    cycles    = 0;
    arst_n    = 1'b0;
    supply_on = 1'b0;
    pulse_go  = 1'b0;
    cpu_ale   = 1'b0;
    cpu_pss   = 1'b0;
    address   = 8'h00;
    read      = 1'b0;
    write     = 1'b0;
    wdata     = 32'h0;
    repeat (6) @(posedge clock);
    arst_n <= 1'b1;
    repeat (3) @(posedge clock);
    t_power_on();
    t_pin_reset();
    t_bus_misc();
    wrap_up();
  end
endmodule // testbench
